// ---- rtl/cwd_pkg.sv ----
package cwd_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_DYNFREQ = 8'h09;
    localparam logic [7:0] OFS_WDCTL = 8'h0a;
    localparam logic [7:0] OFS_DIVLOW = 8'h0b;
    localparam logic [7:0] OFS_DIVHIGH = 8'h0c;
    localparam logic [7:0] OFS_OVERRIDE = 8'h0e;
    localparam logic [7:0] OFS_PROGCTL = 8'h10;

    // field positions outside the struct-mapped bytes
    localparam int BIT_STRAP_BYPASS = 5;
    localparam int BIT_PROG_CPU_EN = 1;
    localparam int BIT_AUTORECOVERY = 0;
    localparam int BIT_FEEDBACK_MSB = 7;

    // reset values
    localparam logic [7:0] RST_DYNFREQ = 8'h00;
    localparam logic [7:0] RST_WDCTL = 8'h20;
    localparam logic [8:0] RST_FEEDBACK = 9'h000;
    localparam logic [6:0] RST_REFDIV = 7'h00;
    localparam logic RST_STRAP_BYPASS = 1'b0;
    localparam logic RST_PROG_CPU_EN = 1'b0;
    localparam logic RST_AUTORECOVERY = 1'b1;

    // timing
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned UNIT_SHORT_MS = 294;
    localparam int unsigned UNIT_LONG_MS = 2340;
    localparam int unsigned UNIT_SHORT_CYC = UNIT_SHORT_MS * (CLK_HZ / 1000);
    localparam int unsigned UNIT_LONG_CYC = UNIT_LONG_MS * (CLK_HZ / 1000);
    localparam int unsigned RESET_PULSE_NS = 640;
    localparam int unsigned RESET_PULSE_CYC = RESET_PULSE_NS / (1_000_000_000 / CLK_HZ);

    // first control byte
    typedef struct packed {
        logic [2:0] dynfreqCeiling;
        logic dynfreqEnable;
        logic [3:0] softFreqCode;
    } cwd_dynfreq_s;

    // watchdog control byte
    typedef struct packed {
        logic recoverySource;
        logic timeoutAction;
        logic timeScale;
        logic expiryFlag;
        logic [2:0] intervalCode;
        logic wdEnable;
    } cwd_wdctl_s;

    // cpu frequency configuration towards the synthesiser
    typedef struct packed {
        logic progCpuEnable;
        logic [8:0] cpuFeedbackCount;
        logic [6:0] cpuRefDivide;
        logic [4:0] ratioCode;
    } cwd_cpucfg_s;

    // recovery request towards the synthesiser
    typedef struct packed {
        logic restoreReq;
        logic fromValue;
        logic [8:0] restoreValue;
    } cwd_restore_s;

endpackage

// ---- rtl/cwd_clock_watchdog.sv ----
`timescale 1ns/1ps

// What this block does
// [R1] three-bit dynamic-frequency ceiling in bits 7:5
// [R2] dynamic-frequency enable at bit 4, reset zero
// [R3] four-bit software frequency code bits 3:0
// [R4] recovery source: strap setting or recovery value
// [R5] timeout action: reset plus reload, or reset
// [R6] time scale 294 ms or 2.34 s, default long
// [R7] alarm set on expiry, cleared with interval
// [R8] timeout equals interval code times unit
// [R9] enable write starts watchdog, loads interval
// [R10] programmed N and M set cpu frequency
// [R11] ratio from straps or soft code per override
// [R12] N low byte, N8 plus M next byte
// [R13] programmable cpu enable defaults off
// [R14] override defaults off, straps govern frequency
// [R15] autorecovery bit defaults on, selects auto
// [R16] reset-output strap latched at power good
// [R17] disabled holds; timeout fires exactly once
module cwd_clock_watchdog
    import cwd_pkg::*;
#(
    parameter int unsigned SHORT_UNIT_CYC = UNIT_SHORT_CYC,
    parameter int unsigned LONG_UNIT_CYC = UNIT_LONG_CYC,
    parameter int CNT_W = 26
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic [4:0] freqStrapPins,
    input wire logic resetOutStrap,
    input wire logic powerGoodN,
    input wire logic [8:0] recoveryValue,
    output logic [2:0] dynfreqCeiling,
    output logic dynfreqEnable,
    output cwd_cpucfg_s cpuCfg,
    output cwd_restore_s restore,
    output logic [4:0] strapLatched,
    output logic systemResetOutN
);

    localparam logic [CNT_W-1:0] SHORT_LAST = CNT_W'(SHORT_UNIT_CYC - 1);
    localparam logic [CNT_W-1:0] LONG_LAST = CNT_W'(LONG_UNIT_CYC - 1);
    localparam logic [7:0] PULSE_LEN = 8'(RESET_PULSE_CYC);

    cwd_dynfreq_s dynfreq_q;
    cwd_wdctl_s wdctl_q;
    cwd_wdctl_s wdctl_d;
    logic [8:0] feedback_q;
    logic [6:0] refDiv_q;
    logic strapBypass_q;
    logic progCpuEn_q;
    logic autoRecovery_q;
    logic [4:0] strap_q;
    logic resetStrap_q;
    logic pgPrev_q;
    logic [CNT_W-1:0] prescale_q;
    logic [2:0] remain_q;
    logic [7:0] pulseCnt_q;
    logic [7:0] rdData_q;
    logic restoreReq_q;
    logic restoreFromValue_q;
    logic [8:0] restoreValue_q;

    // address decode and write strobes
    wire wrDynfreq = regWr && (regAddr == OFS_DYNFREQ);
    wire wrWdctl = regWr && (regAddr == OFS_WDCTL);
    wire wrDivLow = regWr && (regAddr == OFS_DIVLOW);
    wire wrDivHigh = regWr && (regAddr == OFS_DIVHIGH);
    wire wrOverride = regWr && (regAddr == OFS_OVERRIDE);
    wire wrProgCtl = regWr && (regAddr == OFS_PROGCTL);
    wire cwd_wdctl_s wrWd = cwd_wdctl_s'(regWrData);

    // watchdog timing
    wire [CNT_W-1:0] unitLast = wdctl_q.timeScale ? LONG_LAST : SHORT_LAST; // R6
    wire running = wdctl_q.wdEnable && (wdctl_q.intervalCode != 3'h0); // R17
    wire unitTick = running && (prescale_q == unitLast);
    wire timeout = unitTick && (remain_q == 3'h1); // R8
    wire startWd = wrWdctl && wrWd.wdEnable; // R9
    wire clearAlarm = wrWdctl && (wrWd.intervalCode == 3'h0); // R7
    wire pgFall = pgPrev_q && !powerGoodN;

    // next value of the watchdog byte
    always_comb begin
        wdctl_d = wdctl_q;
        if (wrWdctl) begin
            wdctl_d = wrWd;
            wdctl_d.expiryFlag = wdctl_q.expiryFlag && !clearAlarm; // R7
        end
        if (timeout && !startWd) begin
            wdctl_d.wdEnable = 1'b0; // R17
        end
        if (timeout) begin
            wdctl_d.expiryFlag = 1'b1; // R7
        end
    end

    // control registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dynfreq_q <= cwd_dynfreq_s'(RST_DYNFREQ); // R2
            wdctl_q <= cwd_wdctl_s'(RST_WDCTL); // R6
            feedback_q <= RST_FEEDBACK; // R12
            refDiv_q <= RST_REFDIV;
            strapBypass_q <= RST_STRAP_BYPASS; // R14
            progCpuEn_q <= RST_PROG_CPU_EN; // R13
            autoRecovery_q <= RST_AUTORECOVERY; // R15
        end else begin
            wdctl_q <= wdctl_d;
            if (wrDynfreq) begin
                dynfreq_q <= cwd_dynfreq_s'(regWrData); // R1 R2 R3
            end
            if (wrDivLow) begin
                feedback_q[7:0] <= regWrData; // R12
            end
            if (wrDivHigh) begin
                feedback_q[8] <= regWrData[BIT_FEEDBACK_MSB]; // R12
                refDiv_q <= regWrData[6:0];
            end
            if (wrOverride) begin
                strapBypass_q <= regWrData[BIT_STRAP_BYPASS]; // R14
            end
            if (wrProgCtl) begin
                progCpuEn_q <= regWrData[BIT_PROG_CPU_EN]; // R13
                autoRecovery_q <= regWrData[BIT_AUTORECOVERY]; // R15
            end
        end
    end

    // watchdog counters
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_q <= '0;
            remain_q <= 3'h0;
        end else if (startWd) begin
            prescale_q <= '0; // R9
            remain_q <= wrWd.intervalCode; // R9
        end else if (unitTick) begin
            prescale_q <= '0;
            remain_q <= remain_q - 3'h1; // R8
        end else if (running) begin
            prescale_q <= prescale_q + CNT_W'(1);
        end
    end

    // strap capture on power-good assertion
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pgPrev_q <= 1'b1;
            strap_q <= 5'h00;
            resetStrap_q <= 1'b0;
        end else begin
            pgPrev_q <= powerGoodN;
            if (pgFall) begin
                strap_q <= freqStrapPins;
                resetStrap_q <= resetOutStrap; // R16
            end
        end
    end

    // system reset pulse and frequency recovery
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulseCnt_q <= 8'h00;
            restoreReq_q <= 1'b0;
            restoreFromValue_q <= 1'b0;
            restoreValue_q <= 9'h000;
        end else begin
            restoreReq_q <= 1'b0;
            if (timeout && resetStrap_q) begin
                pulseCnt_q <= PULSE_LEN; // R5 R16
            end else if (pulseCnt_q != 8'h00) begin
                pulseCnt_q <= pulseCnt_q - 8'h01;
            end
            if (timeout && !wdctl_q.timeoutAction && autoRecovery_q) begin
                restoreReq_q <= 1'b1; // R5 R15
                restoreFromValue_q <= wdctl_q.recoverySource; // R4
                restoreValue_q <= recoveryValue; // R4
            end
        end
    end

    // readback
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q <= 8'h00;
        end else if (regRd) begin
            unique case (regAddr)
                OFS_DYNFREQ: rdData_q <= dynfreq_q;
                OFS_WDCTL: rdData_q <= wdctl_q;
                OFS_DIVLOW: rdData_q <= feedback_q[7:0];
                OFS_DIVHIGH: rdData_q <= {feedback_q[8], refDiv_q};
                OFS_OVERRIDE: rdData_q <= 8'(strapBypass_q) << BIT_STRAP_BYPASS;
                OFS_PROGCTL: rdData_q <= (8'(progCpuEn_q) << BIT_PROG_CPU_EN)
                                       | (8'(autoRecovery_q) << BIT_AUTORECOVERY);
                default: rdData_q <= 8'h00;
            endcase
        end
    end

    // outputs
    assign regRdData = rdData_q;
    assign dynfreqCeiling = dynfreq_q.dynfreqCeiling; // R1
    assign dynfreqEnable = dynfreq_q.dynfreqEnable; // R2
    assign cpuCfg.progCpuEnable = progCpuEn_q; // R10 R13
    assign cpuCfg.cpuFeedbackCount = feedback_q; // R10
    assign cpuCfg.cpuRefDivide = refDiv_q; // R10
    assign cpuCfg.ratioCode = strapBypass_q ? {1'b0, dynfreq_q.softFreqCode}
                                            : strap_q; // R11 R3
    assign restore.restoreReq = restoreReq_q;
    assign restore.fromValue = restoreFromValue_q;
    assign restore.restoreValue = restoreValue_q;
    assign strapLatched = strap_q;
    assign systemResetOutN = (pulseCnt_q == 8'h00); // R5

endmodule

// ---- verification/cwd_board_model.sv ----
`timescale 1ns/1ps
// board side: strap pins and power good
module cwd_board_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    output logic [4:0] freqStrapPins,
    output logic resetOutStrap,
    output logic powerGoodN
);
    // straps steady at the power-good fall, then the pins carry other levels
    initial begin
        freqStrapPins = 5'h16;
        resetOutStrap = 1'b1;
        powerGoodN = 1'b1;
        @(posedge rst_n);
        repeat (3) @(negedge sys_clk);
        powerGoodN = 1'b0;
        repeat (2) @(negedge sys_clk);
        freqStrapPins = 5'h09;
        resetOutStrap = 1'b0;
    end
endmodule

// ---- verification/cwd_clock_watchdog_asserts.sv ----
`timescale 1ns/1ps
// watches register writes and watchdog outputs
module cwd_checker
    import cwd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic [2:0] dynfreqCeiling,
    input wire logic dynfreqEnable,
    input wire cwd_cpucfg_s cpuCfg,
    input wire cwd_restore_s restore,
    input wire logic [4:0] strapLatched,
    input wire logic systemResetOutN
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // byte write strobes
    wire wrDyn = regWr && regAddr == OFS_DYNFREQ;
    wire wrLow = regWr && regAddr == OFS_DIVLOW;
    wire wrHigh = regWr && regAddr == OFS_DIVHIGH;
    wire wrOvr = regWr && regAddr == OFS_OVERRIDE;
    wire wrWd = regWr && regAddr == OFS_WDCTL;
    property p_df;
        wrDyn |=> {dynfreqCeiling, dynfreqEnable} == $past(regWrData[7:4]);
    endproperty
    a_df: assert property (p_df) else $error("dynfreq fields wrong");
    property p_nl;
        wrLow |=> cpuCfg.cpuFeedbackCount[7:0] == $past(regWrData);
    endproperty
    a_nl: assert property (p_nl) else $error("feedback low wrong");
    property p_nh;
        wrHigh |=> {cpuCfg.cpuFeedbackCount[8], cpuCfg.cpuRefDivide} == $past(regWrData);
    endproperty
    a_nh: assert property (p_nh) else $error("divider high wrong");
    property p_rt;
        wrOvr && !regWrData[5] |=> cpuCfg.ratioCode == strapLatched;
    endproperty
    a_rt: assert property (p_rt) else $error("ratio not from straps");
    property p_pw;
        $fell(systemResetOutN) |-> !systemResetOutN [*8];
    endproperty
    a_pw: assert property (p_pw) else $error("reset pulse short");
    property p_rq;
        restore.restoreReq |=> !restore.restoreReq;
    endproperty
    a_rq: assert property (p_rq) else $error("restore not a pulse");
    property p_er;
        wrWd && regWrData[5:0] == 6'h03 && systemResetOutN |=> systemResetOutN [*2];
    endproperty
    a_er: assert property (p_er) else $error("timeout too early");
    property p_ho;
        wrWd && !regWrData[0] ##1 systemResetOutN [*2] |=> systemResetOutN [*4];
    endproperty
    a_ho: assert property (p_ho) else $error("disabled watchdog fired");
    c_trip: cover property ($fell(systemResetOutN));
    c_req: cover property (restore.restoreReq);
    c_ovr: cover property (wrOvr && regWrData[5]);
endmodule
bind cwd_clock_watchdog cwd_checker i_cwd_checker (.sys_clk(sys_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .dynfreqCeiling(dynfreqCeiling), .dynfreqEnable(dynfreqEnable), .cpuCfg(cpuCfg),
    .restore(restore), .strapLatched(strapLatched), .systemResetOutN(systemResetOutN));

// ---- verification/test_clock_watchdog_freq_program.sv ----
`timescale 1ns/1ps
module test_clock_watchdog_freq_program;
    import cwd_pkg::*;
    logic sys_clk = 0;
    logic rst_n = 0;
    logic regWr = 0;
    logic regRd = 0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic [8:0] recoveryValue = 9'h1c3;
    logic [7:0] regRdData;
    logic [4:0] freqStrapPins, strapLatched;
    logic [2:0] dynfreqCeiling;
    logic resetOutStrap, powerGoodN, dynfreqEnable, systemResetOutN;
    cwd_cpucfg_s cpuCfg;
    cwd_restore_s restore;
    int miscompares = 0;
    int cmpCount = 0;
    // system clock
    always #20 sys_clk = ~sys_clk;
    cwd_board_model i_cwd_board_model (.sys_clk(sys_clk), .rst_n(rst_n),
        .freqStrapPins(freqStrapPins), .resetOutStrap(resetOutStrap), .powerGoodN(powerGoodN));
    cwd_clock_watchdog #(.SHORT_UNIT_CYC(4), .LONG_UNIT_CYC(8)) i_cwd_clock_watchdog (
        .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .freqStrapPins(freqStrapPins),
        .resetOutStrap(resetOutStrap), .powerGoodN(powerGoodN), .recoveryValue(recoveryValue),
        .dynfreqCeiling(dynfreqCeiling), .dynfreqEnable(dynfreqEnable), .cpuCfg(cpuCfg),
        .restore(restore), .strapLatched(strapLatched), .systemResetOutN(systemResetOutN));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmpCount++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regWrData = d;
        regWr = 1'b1;
        @(negedge sys_clk);
        regWr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        regAddr = a;
        regRd = 1'b1;
        @(negedge sys_clk);
        regRd = 1'b0;
        chk(regRdData, e);
    endtask
    // arm watchdog, time expiry, check recovery, pulse and alarm
    task automatic trip(input logic [7:0] c, input logic req, input int u);
        int n;
        n = 0;
        wr(OFS_WDCTL, c);
        while (systemResetOutN !== 1'b0 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        chk(n >= c[3:1] * u && n <= c[3:1] * u + 2, 1'b1);
        chk(restore.restoreReq, req);
        if (req) chk({restore.fromValue, restore.restoreValue}, {c[7], recoveryValue});
        repeat (15) @(negedge sys_clk);
        chk(systemResetOutN, 1'b0);
        @(negedge sys_clk);
        chk(systemResetOutN, 1'b1);
        rd(OFS_WDCTL, {c[7:5], 1'b1, c[3:1], 1'b0});
        wr(OFS_WDCTL, {c[7:5], 5'h00});
        rd(OFS_WDCTL, {c[7:5], 5'h00});
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        test_done;
    end
    // test sequence
    initial begin
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        rd(OFS_DYNFREQ, RST_DYNFREQ);
        rd(OFS_WDCTL, 8'h20);
        rd(OFS_DIVLOW, 8'h00);
        rd(OFS_DIVHIGH, 8'h00);
        rd(OFS_PROGCTL, 8'h01);
        rd(OFS_OVERRIDE, 8'h00);
        rd(8'h20, 8'h00);
        chk(cpuCfg.ratioCode, 5'h16);
        chk(strapLatched, 5'h16);
        $display("reset test done");
        wr(OFS_DYNFREQ, 8'hb5);
        rd(OFS_DYNFREQ, 8'hb5);
        chk({dynfreqCeiling, dynfreqEnable}, 4'hb);
        wr(OFS_DIVLOW, 8'ha5);
        wr(OFS_DIVHIGH, 8'hc3);
        chk({cpuCfg.cpuFeedbackCount, cpuCfg.cpuRefDivide}, 16'hd2c3);
        wr(OFS_PROGCTL, 8'h03);
        chk(cpuCfg.progCpuEnable, 1'b1);
        wr(OFS_OVERRIDE, 8'h20);
        chk(cpuCfg.ratioCode, 5'h05);
        wr(OFS_OVERRIDE, 8'h00);
        chk(cpuCfg.ratioCode, 5'h16);
        wr(OFS_WDCTL, 8'h10);
        rd(OFS_WDCTL, 8'h00);
        $display("register test done");
        for (int s = 0; s < 2; s++)
            for (int k = 1; k < 8; k++)
                trip({2'b10, s[0], 1'b0, k[2:0], 1'b1}, 1'b1, s ? 8 : 4);
        trip(8'h43, 1'b0, 4);
        wr(OFS_PROGCTL, 8'h02);
        trip(8'h03, 1'b0, 4);
        wr(OFS_PROGCTL, 8'h03);
        trip(8'h03, 1'b1, 4);
        wr(OFS_WDCTL, 8'h02);
        repeat (40) @(negedge sys_clk);
        rd(OFS_WDCTL, 8'h02);
        wr(OFS_WDCTL, 8'h01);
        repeat (40) @(negedge sys_clk);
        rd(OFS_WDCTL, 8'h01);
        chk(systemResetOutN, 1'b1);
        $display("watchdog test done");
        // second reset: power good already low, straps latched with reset output off
        @(negedge sys_clk);
        rst_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        rd(OFS_DYNFREQ, RST_DYNFREQ);
        rd(OFS_WDCTL, RST_WDCTL);
        rd(OFS_PROGCTL, 8'h01);
        chk(strapLatched, 5'h09);
        wr(OFS_WDCTL, 8'h83);
        repeat (4) @(negedge sys_clk);
        chk(restore.restoreReq, 1'b1);
        repeat (4) @(negedge sys_clk);
        chk(systemResetOutN, 1'b1);
        rd(OFS_WDCTL, 8'h92);
        $display("second reset test done");
        test_done;
    end
endmodule
